// ==== hw/rhc_pkg.sv ====
package rhc_pkg;
    // Register byte addresses of the four output banks, indexed A, B, C, D
    localparam logic [7:0] RHC_DIV_ADDR [0:3] = '{8'h24, 8'h2c, 8'h34, 8'h40};
    localparam logic [7:0] RHC_PHASE_ADDR [0:3] = '{8'h25, 8'h2d, 8'h35, 8'h41};
    localparam logic [7:0] RHC_CTRL_ADDR [0:3] = '{8'h26, 8'h2e, 8'h36, 8'h42};
    // Bank D fractional divider bytes
    localparam logic [7:0] RHC_FRAC_LOW_ADDR = 8'h3c;
    localparam logic [7:0] RHC_FRAC_MID_ADDR = 8'h3d;
    localparam logic [7:0] RHC_FRAC_HIGH_ADDR = 8'h3e;
    localparam logic [7:0] RHC_FRAC_INT_ADDR = 8'h3f;
    // Output enables
    localparam logic [7:0] RHC_EN_ADDR = 8'h58;
    // Counter configuration, holdover period and status
    localparam logic [7:0] RHC_HOLD_CFG_ADDR = 8'h22;
    localparam logic [7:0] RHC_HOLD_PERIOD_ADDR = 8'h23;
    localparam logic [7:0] RHC_STATUS_ADDR = 8'h5f;

    // Field positions
    localparam int RHC_PD_BIT = 7;
    localparam int RHC_SEL_BIT = 0;
    localparam int RHC_DSRC_BIT = 1;
    localparam int RHC_DPOST_LSB = 2;
    localparam int RHC_EN_V_BIT = 4;
    localparam int RHC_PRESCALE_LSB = 0;
    localparam int RHC_REVAL_LSB = 2;

    // Writable masks; every other bit is reserved and reads zero
    localparam logic [7:0] RHC_CTRL_MASK_ABC = 8'h81;
    localparam logic [7:0] RHC_CTRL_MASK_D = 8'h8f;
    localparam logic [7:0] RHC_INT_MASK = 8'h0f;
    localparam logic [7:0] RHC_EN_MASK = 8'h1f;

    // Reset values
    localparam logic [7:0] RHC_DIV_RST = 8'h46;
    localparam logic [7:0] RHC_PHASE_RST = 8'h00;
    localparam logic [7:0] RHC_CTRL_RST = 8'h00;
    localparam logic [23:0] RHC_FRAC_RST = 24'h600000;
    localparam logic [3:0] RHC_INT_RST = 4'h9;
    localparam logic [4:0] RHC_EN_RST = 5'h00;
    localparam logic [1:0] RHC_PRESCALE_RST = 2'h2;
    localparam logic [1:0] RHC_REVAL_RST = 2'h2;
    localparam logic [7:0] RHC_HOLD_PERIOD_RST = 8'h80;

    // Prescaler codes
    typedef enum logic [1:0] {
        RHC_PRE_DIV15 = 2'h0,
        RHC_PRE_DIV16 = 2'h1,
        RHC_PRE_DIV17 = 2'h2,
        RHC_PRE_RSVD = 2'h3
    } rhc_prescale_type;

    // Cycles without a reference edge counted as one missing period
    localparam int RHC_GAP_LIMIT = 16;

    // Required good periods for each revalidation code
    function automatic logic [6:0] rhc_reval_count(input logic [1:0] sel);
        case (sel)
            2'h0: rhc_reval_count = 7'h02;
            2'h1: rhc_reval_count = 7'h10;
            2'h2: rhc_reval_count = 7'h20;
            default: rhc_reval_count = 7'h40;
        endcase
    endfunction : rhc_reval_count
endpackage : rhc_pkg

// ==== hw/rhc_reval.sv ====
`timescale 1ns/1ps
module rhc_reval
    import rhc_pkg::*;
#(
    parameter int GAP_LIMIT = RHC_GAP_LIMIT
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic ref_edge_i,
    input wire logic los_event_i,
    input wire logic [1:0] count_sel_i,
    output logic loss_of_signal_o,
    output logic revalidated_o
);
    logic [6:0] cnt_r; // Remaining good periods
    logic [7:0] gap_r; // Cycles since the last reference edge
    logic loss_r; // Sticky loss flag
    logic reval_r; // One-cycle revalidation pulse
    logic gap_hit; // One whole period without an edge
    logic zero_hit; // Counter steps from one to zero

    assign gap_hit = loss_r && !ref_edge_i && (gap_r >= 8'(GAP_LIMIT - 1));
    assign zero_hit = loss_r && !los_event_i && !gap_hit && ref_edge_i && (cnt_r == 7'h01);

    // Period watchdog, restarted by every edge or a missed period
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            gap_r <= 8'h00;
        end else if (ref_edge_i || !loss_r || los_event_i || gap_hit) begin
            gap_r <= 8'h00;
        end else begin
            gap_r <= gap_r + 8'h01;
        end
    end

    // Countdown of good periods
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            cnt_r <= 7'h00;
        end else if (los_event_i) begin
            cnt_r <= rhc_reval_count(count_sel_i);
        end else if (gap_hit) begin
            cnt_r <= rhc_reval_count(count_sel_i);
        end else if (loss_r && ref_edge_i && cnt_r != 7'h00) begin
            cnt_r <= cnt_r - 7'h01;
        end
    end

    // Loss flag; a new loss event wins over a clear in the same cycle
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            loss_r <= 1'b0;
            reval_r <= 1'b0;
        end else begin
            reval_r <= zero_hit;
            if (los_event_i) begin
                loss_r <= 1'b1;
            end else if (zero_hit) begin
                loss_r <= 1'b0;
            end
        end
    end

    assign loss_of_signal_o = loss_r;
    assign revalidated_o = reval_r;

    sequence s_los_load;
        los_event_i ##1 loss_r;
    endsequence

    AST_RV_LOAD: assert property (@(posedge clk_i) disable iff (rst_i)
        los_event_i |=> (cnt_r == rhc_reval_count($past(count_sel_i))) && loss_r)
        else $error("revalidation counter not loaded on loss event");
    AST_RV_DEC: assert property (@(posedge clk_i) disable iff (rst_i)
        (loss_r && ref_edge_i && !los_event_i && cnt_r > 7'h01) |=>
        (cnt_r == $past(cnt_r) - 7'h01))
        else $error("revalidation counter did not step by one");
    AST_RV_CLEAR: assert property (@(posedge clk_i) disable iff (rst_i)
        zero_hit |=> !loss_r && cnt_r == 7'h00 && revalidated_o)
        else $error("loss flag not cleared at zero");
    AST_RV_HOLD: assert property (@(posedge clk_i) disable iff (rst_i)
        s_los_load |-> !revalidated_o [*2])
        else $error("revalidated too soon after a loss event");
endmodule : rhc_reval

// ==== hw/rhc_hold.sv ====
`timescale 1ns/1ps
module rhc_hold
    import rhc_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic run_i,
    input wire logic [1:0] prescale_sel_i,
    input wire logic [7:0] holdover_period_i,
    output logic failover_o,
    output logic [7:0] holdover_count_o
);
    logic [16:0] pre_r; // Free-running prescaler
    logic [7:0] cnt_r; // Holdover countdown
    logic fail_r; // One-cycle fail-over pulse
    logic tick; // Prescaled holdover clock

    // Reserved code behaves as the slowest rate so the counter never races
    always_comb begin
        case (rhc_prescale_type'(prescale_sel_i))
            RHC_PRE_DIV15: tick = &pre_r[14:0];
            RHC_PRE_DIV16: tick = &pre_r[15:0];
            RHC_PRE_DIV17: tick = &pre_r[16:0];
            default: tick = &pre_r[16:0];
        endcase
    end

    // Prescaler
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            pre_r <= 17'h00000;
        end else begin
            pre_r <= pre_r + 17'h00001;
        end
    end

    // Countdown, reloading after every expiry
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            cnt_r <= RHC_HOLD_PERIOD_RST;
            fail_r <= 1'b0;
        end else begin
            fail_r <= 1'b0;
            if (!run_i) begin
                cnt_r <= holdover_period_i;
            end else if (tick) begin
                if (cnt_r <= 8'h01) begin
                    cnt_r <= holdover_period_i;
                    fail_r <= 1'b1;
                end else begin
                    cnt_r <= cnt_r - 8'h01;
                end
            end
        end
    end

    assign failover_o = fail_r;
    assign holdover_count_o = cnt_r;

    AST_HO_EXPIRE: assert property (@(posedge clk_i) disable iff (rst_i)
        (run_i && tick && cnt_r == 8'h01) |=> failover_o && cnt_r == $past(holdover_period_i))
        else $error("holdover expiry missed");
    AST_HO_RATE: assert property (@(posedge clk_i) disable iff (rst_i)
        (prescale_sel_i == 2'h0 && tick) |-> pre_r[14:0] == 15'h7fff)
        else $error("prescaler tick at wrong phase");
endmodule : rhc_hold

// ==== hw/rhc_regs.sv ====
`timescale 1ns/1ps
// Summary of operation
// - Prescaler divides VCXO by 2^15, 2^16, 2^17
// - Loss event loads revalidation counter
// - Each good period decrements by one
// - Missing period reloads and restarts countdown
// - Reaching zero clears the loss flag
// - Codes select 2, 16, 32, 64 periods
// - Integer dividers at 0x24, 0x2C, 0x34, 0x40
// - Phase delays at 0x25, 0x2D, 0x35, 0x41
// - Control bytes: power-down D7, source D0
// - Fractional bytes at 0x3C, 0x3D, 0x3E
// - Holdover counts down, fails over, reloads
// - Source bit picks pin or register settings
// - Bank D source selects integer or fractional
// - Disabled bank outputs held low
module rhc_regs
    import rhc_pkg::*;
#(
    parameter int NUM_BANKS = 4,
    parameter int GAP_LIMIT = RHC_GAP_LIMIT
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [7:0] reg_addr_i,
    input wire logic [7:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    output logic [7:0] reg_rdata_o,
    input wire logic [1:0] ref_clk_i,
    input wire logic [1:0] los_event_i,
    input wire logic [NUM_BANKS*8-1:0] pin_div_i,
    input wire logic [NUM_BANKS-1:0] pin_pd_i,
    input wire logic [NUM_BANKS-1:0] pin_en_i,
    input wire logic [NUM_BANKS-1:0] bank_clk_i,
    output logic [NUM_BANKS-1:0] bank_out_o,
    output logic [NUM_BANKS*8-1:0] eff_div_o,
    output logic [NUM_BANKS*8-1:0] phase_delay_o,
    output logic [NUM_BANKS-1:0] bank_power_down_o,
    output logic [NUM_BANKS-1:0] bank_enable_o,
    output logic bank_d_source_sel_o,
    output logic [1:0] frac_post_div_o,
    output logic [23:0] frac_value_o,
    output logic [3:0] frac_int_o,
    output logic vcxo_output_enable_o,
    output logic [1:0] loss_of_signal_o,
    output logic [1:0] revalidated_o,
    output logic failover_o
);
    logic [7:0] div_r [0:NUM_BANKS-1]; // Integer divider per bank
    logic [7:0] phase_r [0:NUM_BANKS-1]; // Phase delay per bank
    logic [7:0] ctrl_r [0:NUM_BANKS-1]; // Control byte, reserved bits zero
    logic [23:0] frac_r; // Bank D fractional part
    logic [3:0] int_r; // Bank D fractional integer part
    logic [4:0] en_r; // Output enables, V then A to D
    logic [1:0] prescale_r; // Holdover prescaler code
    logic [1:0] reval_r; // Revalidation count code
    logic [7:0] period_r; // Holdover period
    logic [7:0] rdata_r; // Registered read answer
    logic [7:0] rd_nxt; // Read mux
    logic [1:0] sync1_r; // First synchroniser stage
    logic [1:0] sync2_r; // Second synchroniser stage
    logic [1:0] sync3_r; // Edge detect history
    logic [1:0] ref_edge; // Rising edge of each reference
    logic [NUM_BANKS-1:0] gate_r; // Registered drive enable per bank

    // Pin settings are same-clock levels, not synchronised;
    // the board must hold them steady against the VCXO clock

    // Reference inputs cross into the VCXO domain before edge detection
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            sync1_r <= 2'h0;
            sync2_r <= 2'h0;
            sync3_r <= 2'h0;
        end else begin
            sync1_r <= ref_clk_i;
            sync2_r <= sync1_r;
            sync3_r <= sync2_r;
        end
    end
    // Only the second and third stages feed logic;
    // a pin edge reaches the counters three cycles later
    assign ref_edge = sync2_r & ~sync3_r;

    // Per-bank registers
    // Bank D alone has source and post divider bits
    for (genvar b = 0; b < NUM_BANKS; b++) begin : g_bank
        localparam logic [7:0] CTRL_MASK = (b == 3) ? RHC_CTRL_MASK_D : RHC_CTRL_MASK_ABC;
        logic sel; // Register (1) or pin (0) settings
        logic pd_eff; // Resolved power-down
        logic en_eff; // Resolved enable

        // Divider and phase bytes
        always_ff @(posedge clk_i or posedge rst_i) begin
            if (rst_i) begin
                div_r[b] <= RHC_DIV_RST;
                phase_r[b] <= RHC_PHASE_RST;
            end else if (reg_wr_i) begin
                if (reg_addr_i == RHC_DIV_ADDR[b]) begin
                    div_r[b] <= reg_wdata_i;
                end
                if (reg_addr_i == RHC_PHASE_ADDR[b]) begin
                    phase_r[b] <= reg_wdata_i;
                end
            end
        end

        // Control byte; reserved bits never store
        always_ff @(posedge clk_i or posedge rst_i) begin
            if (rst_i) begin
                ctrl_r[b] <= RHC_CTRL_RST;
            end else if (reg_wr_i && reg_addr_i == RHC_CTRL_ADDR[b]) begin
                ctrl_r[b] <= reg_wdata_i & CTRL_MASK;
            end
        end

        assign sel = ctrl_r[b][RHC_SEL_BIT];
        // Only the low six divider bits follow the pins
        assign pd_eff = sel ? ctrl_r[b][RHC_PD_BIT] : pin_pd_i[b];
        assign en_eff = sel ? en_r[3-b] : pin_en_i[b];

        // Resolved settings come from flops so they change cleanly
        always_ff @(posedge clk_i or posedge rst_i) begin
            if (rst_i) begin
                eff_div_o[b*8 +: 8] <= RHC_DIV_RST;
                phase_delay_o[b*8 +: 8] <= RHC_PHASE_RST;
                bank_power_down_o[b] <= 1'b0;
                bank_enable_o[b] <= 1'b0;
                gate_r[b] <= 1'b0;
            end else begin
                eff_div_o[b*8 +: 8] <= sel ? div_r[b] :
                    {div_r[b][7:6], pin_div_i[b*8 +: 6]};
                phase_delay_o[b*8 +: 8] <= phase_r[b];
                bank_power_down_o[b] <= pd_eff;
                bank_enable_o[b] <= en_eff;
                gate_r[b] <= en_eff && !pd_eff;
            end
        end

        // A disabled or powered-down bank is forced low, never floated
        assign bank_out_o[b] = bank_clk_i[b] & gate_r[b];

        // The gate lags a register write by one cycle
        AST_BANK_LOW: assert property (@(posedge clk_i) disable iff (rst_i)
            (sel && !en_r[3-b]) |=> !bank_out_o[b])
            else $error("disabled bank output not low");
    end

    // Bank D fractional divider and integer part
    // Bytes land alone; the host orders them to avoid a torn value
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            frac_r <= RHC_FRAC_RST;
            int_r <= RHC_INT_RST;
        end else if (reg_wr_i) begin
            case (reg_addr_i)
                RHC_FRAC_LOW_ADDR: frac_r[7:0] <= reg_wdata_i;
                RHC_FRAC_MID_ADDR: frac_r[15:8] <= reg_wdata_i;
                RHC_FRAC_HIGH_ADDR: frac_r[23:16] <= reg_wdata_i;
                RHC_FRAC_INT_ADDR: int_r <= reg_wdata_i[3:0];
                default: ;
            endcase
        end
    end

    // Output enables and counter configuration
    // A new revalidation code applies from the next load
    // A new prescale code applies at once
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            en_r <= RHC_EN_RST;
            prescale_r <= RHC_PRESCALE_RST;
            reval_r <= RHC_REVAL_RST;
            period_r <= RHC_HOLD_PERIOD_RST;
        end else if (reg_wr_i) begin
            case (reg_addr_i)
                RHC_EN_ADDR: en_r <= reg_wdata_i[4:0];
                RHC_HOLD_CFG_ADDR: begin
                    prescale_r <= reg_wdata_i[RHC_PRESCALE_LSB +: 2];
                    reval_r <= reg_wdata_i[RHC_REVAL_LSB +: 2];
                end
                RHC_HOLD_PERIOD_ADDR: period_r <= reg_wdata_i;
                default: ;
            endcase
        end
    end

    // Bank D routing and VCXO output enable
    // Post divider code 11 is passed on as written
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            bank_d_source_sel_o <= 1'b0;
            frac_post_div_o <= 2'h0;
            frac_value_o <= RHC_FRAC_RST;
            frac_int_o <= RHC_INT_RST;
            vcxo_output_enable_o <= 1'b0;
        end else begin
            bank_d_source_sel_o <= ctrl_r[3][RHC_DSRC_BIT];
            frac_post_div_o <= ctrl_r[3][RHC_DPOST_LSB +: 2];
            frac_value_o <= frac_r;
            frac_int_o <= int_r;
            vcxo_output_enable_o <= en_r[RHC_EN_V_BIT];
        end
    end

    // Read mux; unmapped addresses answer zero
    always_comb begin
        rd_nxt = 8'h00;
        for (int b = 0; b < NUM_BANKS; b++) begin
            if (reg_addr_i == RHC_DIV_ADDR[b]) begin
                rd_nxt = div_r[b];
            end
            if (reg_addr_i == RHC_PHASE_ADDR[b]) begin
                rd_nxt = phase_r[b];
            end
            if (reg_addr_i == RHC_CTRL_ADDR[b]) begin
                rd_nxt = ctrl_r[b];
            end
        end
        case (reg_addr_i)
            RHC_FRAC_LOW_ADDR: rd_nxt = frac_r[7:0];
            RHC_FRAC_MID_ADDR: rd_nxt = frac_r[15:8];
            RHC_FRAC_HIGH_ADDR: rd_nxt = frac_r[23:16];
            RHC_FRAC_INT_ADDR: rd_nxt = {4'h0, int_r} & RHC_INT_MASK;
            RHC_EN_ADDR: rd_nxt = {3'h0, en_r} & RHC_EN_MASK;
            RHC_HOLD_CFG_ADDR: rd_nxt = {4'h0, reval_r, prescale_r};
            RHC_HOLD_PERIOD_ADDR: rd_nxt = period_r;
            RHC_STATUS_ADDR: rd_nxt = {6'h00, loss_of_signal_o};
            default: ;
        endcase
    end

    // Read answer held until the next read
    // A read and a write in one cycle return the old value
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            rdata_r <= 8'h00;
        end else if (reg_rd_i) begin
            rdata_r <= rd_nxt;
        end
    end
    assign reg_rdata_o = rdata_r;

    // One revalidation counter per reference input
    // Both inputs share one count code; flags are separate
    for (genvar n = 0; n < 2; n++) begin : g_ref
        rhc_reval #(
            .GAP_LIMIT(GAP_LIMIT)
        ) u_reval (
            .clk_i(clk_i),
            .rst_i(rst_i),
            .ref_edge_i(ref_edge[n]),
            .los_event_i(los_event_i[n]),
            .count_sel_i(reval_r),
            .loss_of_signal_o(loss_of_signal_o[n]),
            .revalidated_o(revalidated_o[n])
        );
    end

    // Holdover runs while either input is lost
    // The running holdover count stays internal
    rhc_hold u_hold (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .run_i(|loss_of_signal_o),
        .prescale_sel_i(prescale_r),
        .holdover_period_i(period_r),
        .failover_o(failover_o),
        .holdover_count_o()
    );

    // Register-side checks

    AST_RSVD_ZERO: assert property (@(posedge clk_i) disable iff (rst_i)
        (reg_rd_i && reg_addr_i == RHC_CTRL_ADDR[0]) |=> reg_rdata_o[6:1] == 6'h00)
        else $error("reserved control bits read nonzero");

    sequence s_div_wr_rd;
        (reg_wr_i && reg_addr_i == RHC_DIV_ADDR[3]) ##1 !reg_wr_i ##1
        (reg_rd_i && !reg_wr_i && reg_addr_i == RHC_DIV_ADDR[3]);
    endsequence

    AST_DIV_WRITE: assert property (@(posedge clk_i) disable iff (rst_i)
        s_div_wr_rd |=> reg_rdata_o == $past(reg_wdata_i, 3))
        else $error("bank D divider readback mismatch");

    AST_FRAC_HIGH: assert property (@(posedge clk_i) disable iff (rst_i)
        (reg_wr_i && reg_addr_i == RHC_FRAC_HIGH_ADDR) |=> ##1
        frac_value_o[23:16] == $past(reg_wdata_i, 2))
        else $error("fractional high byte not routed");

    AST_DSRC: assert property (@(posedge clk_i) disable iff (rst_i)
        (reg_wr_i && reg_addr_i == RHC_CTRL_ADDR[3]) |=> ##1
        bank_d_source_sel_o == $past(reg_wdata_i[RHC_DSRC_BIT], 2))
        else $error("bank D source select not applied");

    AST_PIN_DIV: assert property (@(posedge clk_i) disable iff (rst_i)
        !ctrl_r[3][RHC_SEL_BIT] |=> eff_div_o[29:24] == $past(pin_div_i[29:24]))
        else $error("bank D pin divider bits not followed");
endmodule : rhc_regs

// ==== verification/rhc_host.sv ====
`timescale 1ns/1ps
// Serial host stand-in: byte writes and reads, one strobe cycle each
module rhc_host (
    input wire logic clk_i,
    output logic [7:0] reg_addr_o,
    output logic [7:0] reg_wdata_o,
    output logic reg_wr_o,
    output logic reg_rd_o,
    input wire logic [7:0] reg_rdata_i
);
    // Idle bus at time zero
    initial begin
        reg_addr_o = 8'h00;
        reg_wdata_o = 8'h00;
        reg_wr_o = 1'b0;
        reg_rd_o = 1'b0;
    end

    // Strobe stands for exactly one rising edge; released bus shows inverted junk
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk_i);
        reg_addr_o = a;
        reg_wdata_o = d;
        reg_wr_o = 1'b1;
        @(negedge clk_i);
        reg_wr_o = 1'b0;
        reg_addr_o = ~a;
        reg_wdata_o = ~d;
    endtask : wr

    // Data is taken at the falling edge half a cycle after the read edge, where it has settled
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(negedge clk_i);
        reg_addr_o = a;
        reg_rd_o = 1'b1;
        @(negedge clk_i);
        reg_rd_o = 1'b0;
        reg_addr_o = ~a;
        d = reg_rdata_i;
    endtask : rd
endmodule : rhc_host

// ==== verification/tb_top.sv ====
`timescale 1ns/1ps
module tb_top;
    import rhc_pkg::*;
    logic clk_i, rst_i, reg_wr_i, reg_rd_i;
    logic [7:0] reg_addr_i, reg_wdata_i, reg_rdata_o, d;
    logic [1:0] ref_clk_i, los_event_i, loss_of_signal_o, revalidated_o;
    logic [31:0] pin_div_i, eff_div_o, seed, phase_delay_o;
    logic [3:0] pin_pd_i, pin_en_i, bank_clk_i, bank_out_o, bank_power_down_o, bank_enable_o;
    logic bank_d_source_sel_o, failover_o, vcxo_output_enable_o;
    logic [23:0] frac_value_o;
    int bad_count = 0;
    int samples_checked = 0;
    // Every writable address the bench writes and reads back
    logic [7:0] addrs [19] = '{8'h24, 8'h25, 8'h26, 8'h2c, 8'h2d, 8'h2e, 8'h34, 8'h35, 8'h36,
        8'h3c, 8'h3d, 8'h3e, 8'h3f, 8'h40, 8'h41, 8'h42, 8'h58, 8'h22, 8'h23};
    int mdl [19]; // Expected contents after the random writes

    rhc_host host (.clk_i(clk_i), .reg_addr_o(reg_addr_i), .reg_wdata_o(reg_wdata_i),
        .reg_wr_o(reg_wr_i), .reg_rd_o(reg_rd_i), .reg_rdata_i(reg_rdata_o));

    rhc_regs dut (.clk_i(clk_i), .rst_i(rst_i), .reg_addr_i(reg_addr_i),
        .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
        .reg_rdata_o(reg_rdata_o), .ref_clk_i(ref_clk_i), .los_event_i(los_event_i),
        .pin_div_i(pin_div_i), .pin_pd_i(pin_pd_i), .pin_en_i(pin_en_i),
        .bank_clk_i(bank_clk_i), .bank_out_o(bank_out_o), .eff_div_o(eff_div_o),
        .phase_delay_o(phase_delay_o), .bank_power_down_o(bank_power_down_o),
        .bank_enable_o(bank_enable_o), .bank_d_source_sel_o(bank_d_source_sel_o),
        .frac_post_div_o(), .frac_value_o(frac_value_o), .frac_int_o(),
        .vcxo_output_enable_o(vcxo_output_enable_o), .loss_of_signal_o(loss_of_signal_o),
        .revalidated_o(revalidated_o), .failover_o(failover_o));

    // Clock and a free-toggling bank clock changed at falling edges
    initial begin
        clk_i = 1'b0;
        forever #12.5 clk_i = ~clk_i;
    end
    initial bank_clk_i = 4'h0;
    always @(negedge clk_i) bank_clk_i <= ~bank_clk_i;

    function automatic logic [31:0] lfsr(input logic [31:0] x);
        lfsr = {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction : lfsr

    // Writable bits per address; unmapped places hold nothing
    function automatic int wmask(input logic [7:0] a);
        case (a)
            8'h26, 8'h2e, 8'h36: wmask = 'h81;
            8'h42: wmask = 'h8f;
            8'h3f: wmask = 'h0f;
            8'h58: wmask = 'h1f;
            8'h22: wmask = 'h0f;
            8'h24, 8'h25, 8'h2c, 8'h2d, 8'h34, 8'h35, 8'h40, 8'h41: wmask = 'hff;
            8'h3c, 8'h3d, 8'h3e, 8'h23: wmask = 'hff;
            default: wmask = 0;
        endcase
    endfunction : wmask

    function automatic int rstv(input logic [7:0] a);
        case (a)
            8'h24, 8'h2c, 8'h34, 8'h40: rstv = 'h46;
            8'h3e: rstv = 'h60;
            8'h3f: rstv = 9;
            8'h22: rstv = 'h0a; // Both counter codes at binary 10
            8'h23: rstv = 'h80;
            default: rstv = 0;
        endcase
    endfunction : rstv

    task automatic chk(input string what, input logic [31:0] e, input logic [31:0] g);
        samples_checked++;
        if (e !== g) begin
            bad_count++;
            $display("CHECK FAILED %s expected %h seen %h", what, e, g);
        end
    endtask : chk

    task automatic wrap_up();
        $display("comparisons %0d mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask : wrap_up

    // Reference pulses every six cycles, well inside the missing-period window
    task automatic edges(input int k, input int n);
        repeat (n) begin
            @(negedge clk_i) ref_clk_i[k] = 1'b1;
            repeat (3) @(negedge clk_i);
            ref_clk_i[k] = 1'b0;
            repeat (2) @(negedge clk_i);
        end
    endtask : edges

    // Loss event, optional broken run, then exactly the required count
    task automatic reval(input int k, input int code, input int early);
        int need, pulses;
        need = (code == 0) ? 2 : (code == 1) ? 16 : (code == 2) ? 32 : 64;
        host.wr(8'h22, 8'(code << 2));
        @(negedge clk_i) los_event_i[k] = 1'b1;
        @(negedge clk_i) los_event_i[k] = 1'b0;
        chk("loss set", 1, loss_of_signal_o[k]);
        if (early > 0) begin
            edges(k, early);
            repeat (30) @(negedge clk_i);
        end
        edges(k, need - 1);
        repeat (4) @(negedge clk_i);
        chk("loss one short", 1, loss_of_signal_o[k]);
        // Last edge held high while the one-cycle pulse is counted
        @(negedge clk_i) ref_clk_i[k] = 1'b1;
        pulses = 0;
        repeat (8) @(negedge clk_i) pulses += revalidated_o[k];
        ref_clk_i[k] = 1'b0;
        chk("loss cleared", 0, loss_of_signal_o[k]);
        chk("revalidated pulses", 1, pulses);
    endtask : reval

    initial begin
        int gap;
        rst_i = 1'b1;
        los_event_i = 2'h0;
        ref_clk_i = 2'h0;
        seed = 32'h058abc6a;
        pin_div_i = seed;
        pin_pd_i = 4'h0;
        pin_en_i = 4'h0;
        repeat (3) @(negedge clk_i);
        rst_i = 1'b0;
        foreach (addrs[i]) begin
            host.rd(addrs[i], d);
            chk("reset value", rstv(addrs[i]), d);
        end
        // Random contents; prescaler code 11 is never programmed
        foreach (addrs[i]) begin
            seed = lfsr(seed);
            d = (addrs[i] == 8'h22) ? (seed[7:0] & 8'hfd) : seed[7:0];
            mdl[i] = d & wmask(addrs[i]);
            host.wr(addrs[i], d);
        end
        host.wr(8'h50, seed[15:8]);
        host.rd(8'h50, d);
        chk("unmapped read", 0, d);
        foreach (addrs[i]) begin
            host.rd(addrs[i], d);
            chk("readback", mdl[i], d);
        end
        chk("frac value", (mdl[11] << 16) | (mdl[10] << 8) | mdl[9], frac_value_o);
        chk("bank d phase", mdl[14], phase_delay_o[31:24]);
        chk("vcxo enable", mdl[16] >> 4, vcxo_output_enable_o);
        // Bank D: register source, powered down, fractional path
        seed = lfsr(seed);
        pin_div_i = seed;
        pin_en_i = seed[11:8];
        host.wr(8'h58, 8'h01);
        host.wr(8'h42, 8'h83);
        repeat (3) @(negedge clk_i);
        chk("bank d power down", 1, bank_power_down_o[3]);
        chk("bank d source", 1, bank_d_source_sel_o);
        chk("bank d gated", 0, bank_out_o[3]);
        host.wr(8'h42, 8'h01);
        host.wr(8'h40, seed[23:16]);
        host.rd(8'h40, d);
        chk("bank d divider readback", seed[23:16], d);
        repeat (3) @(negedge clk_i);
        chk("bank d divider", seed[23:16], eff_div_o[31:24]);
        chk("bank d integer path", 0, bank_d_source_sel_o);
        repeat (2) @(negedge clk_i) chk("bank d out", bank_clk_i[3], bank_out_o[3]);
        host.wr(8'h42, 8'h00);
        repeat (3) @(negedge clk_i);
        chk("pin divider", {seed[23:22], pin_div_i[29:24]}, eff_div_o[31:24]);
        chk("pin enable", pin_en_i[3], bank_enable_o[3]);
        chk("pin out", bank_clk_i[3] & pin_en_i[3], bank_out_o[3]);
        // Every revalidation code, one run broken by a missing period
        for (int c = 0; c < 4; c++) reval(c % 2, c, (c == 1) ? 5 : 0);
        // Holdover: period 1, fastest prescaler, spacing of fail-overs
        host.wr(8'h23, 8'h01);
        host.wr(8'h22, 8'h00);
        @(negedge clk_i) los_event_i[1] = 1'b1;
        @(negedge clk_i) los_event_i[1] = 1'b0;
        gap = 0;
        while (failover_o !== 1'b1 && gap < 40000) @(negedge clk_i) gap++;
        if (gap >= 40000) begin
            chk("first failover", 1, 0);
        end else begin
            gap = 0;
            @(negedge clk_i);
            while (failover_o !== 1'b1 && gap < 40000) @(negedge clk_i) gap++;
            chk("failover spacing", 32768, gap + 1);
        end
        wrap_up();
    end
endmodule : tb_top
